//--- src/ebr_defs.svh
// Purpose: named offsets, fields, codes and reset values of the event readout
// Assumes: 16-bit register port, 32-bit buffer reads at offsets 0x0000 to 0x0ffc
// Notes:   definitions only
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH
`define EBR_OFF_BUF       16'h0000
`define EBR_OFF_BUF_LAST  16'h0ffc
`define EBR_OFF_SLOT      16'h1002
`define EBR_OFF_GRP       16'h1004
`define EBR_OFF_SET1      16'h1006
`define EBR_OFF_CLR1      16'h1008
`define EBR_OFF_MC_LO     16'h1006
`define EBR_OFF_MC_HI     16'h10bf
`define EBR_GRP_RST       8'haa
`define EBR_SLOT_RST      5'h1f
// power-on slot load waits out the two synchroniser stages
`define EBR_BOOT_INIT     3'h4
`define EBR_TYPE_HDR      3'h2
`define EBR_TYPE_DATA     3'h0
`define EBR_TYPE_EOE      3'h4
`define EBR_TYPE_FILL     3'h6
`define EBR_B_BERR        3
`define EBR_B_SELADDR     4
`define EBR_B_HOLDRST     7
`define EBR_S2_OVKEEP     3
`define EBR_S2_UNKEEP     4
`define EBR_S2_INVKEEP    5
`define EBR_SET1_MASK     16'h0098
`define EBR_FIFO_DEPTH    8
`endif

//--- src/ebr_pkg.sv
// Purpose: shared types of the event readout block
// Assumes: nothing
// Notes:   constants live in ebr_defs.svh
package ebr_pkg;
   typedef enum logic [1:0] {EBR_IDLE, EBR_HDR, EBR_DATA, EBR_EOE} ebr_fmt_e;
   typedef logic [31:0] ebr_word_t;
endpackage : ebr_pkg

//--- src/ebr_event_readout.sv
// Purpose: event record framer, output buffer and control registers
// Assumes: captured channel results arrive indexed by channel number; the framer sets the scan order
// Notes:   16-bit register port with a 32-bit read path for the buffer
`timescale 1ns/1ps
`include "ebr_defs.svh"

module ebr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];

   always_ff @(posedge clk) begin
      if (push) mem_r[wp_r] <= in_data;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (flush) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= AW'((wp_r == AW'(DEPTH-1)) ? 0 : wp_r + 1'b1);
         if (pop)  rp_r <= AW'((rp_r == AW'(DEPTH-1)) ? 0 : rp_r + 1'b1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // ebr_fifo

module ebr_event_readout #(
   parameter bit CH16 = 1'b0
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 hw_reset,
   input  wire logic [4:0]           backplane_slot_connector,
   input  wire logic                 aux_slot_connector,
   input  wire logic [7:0]           crate_number,
   input  wire logic [15:0]          set_two,
   input  wire logic                 ev_valid,
   output logic                      ev_ready,
   input  wire logic [32*12-1:0]     ev_value,
   input  wire logic [31:0]          ev_good,
   input  wire logic [31:0]          ev_below,
   input  wire logic [31:0]          ev_over,
   input  wire logic [31:0]          ch_enable,
   input  wire logic [23:0]          event_count,
   input  wire logic                 blk_berr,
   input  wire logic                 reg_sel,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_group,
   input  wire logic [15:0]          reg_addr,
   input  wire logic [15:0]          reg_wdata,
   output logic                      reg_ack,
   output ebr_pkg::ebr_word_t        reg_rdata,
   output logic                      no_slot_source,
   output logic                      base_relocation_sel,
   output logic                      module_reset,
   output logic [7:0]                group_addr
);
   import ebr_pkg::*;

   // sync of pin-level inputs
   logic [4:0] slot_s1_r, slot_s2_r;
   logic       aux_s1_r, aux_s2_r, hw_s1_r, hw_s2_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_s1_r <= '0;
         slot_s2_r <= '0;
         aux_s1_r  <= 1'b0;
         aux_s2_r  <= 1'b0;
         hw_s1_r   <= 1'b0;
         hw_s2_r   <= 1'b0;
      end else begin
         slot_s1_r <= backplane_slot_connector;
         slot_s2_r <= slot_s1_r;
         aux_s1_r  <= aux_slot_connector;
         aux_s2_r  <= aux_s1_r;
         hw_s1_r   <= hw_reset;
         hw_s2_r   <= hw_s1_r;
      end
   end

   // register access decode
   logic [15:0] set1_r;
   logic [7:0]  grp_r;
   logic [4:0]  slot_r, slot_wr_r;
   logic        slot_pend_r;
   logic [2:0]  boot_r;
   wire hit_buf  = reg_addr <= `EBR_OFF_BUF_LAST;
   wire hit_slot = reg_addr == `EBR_OFF_SLOT;
   wire hit_grp  = reg_addr == `EBR_OFF_GRP;
   wire hit_set  = reg_addr == `EBR_OFF_SET1;
   wire hit_clr  = reg_addr == `EBR_OFF_CLR1;
   // group cycles reach only the write range; reads never answer
   wire grp_ok   = reg_wr && reg_addr >= `EBR_OFF_MC_LO
                   && reg_addr <= `EBR_OFF_MC_HI;
   // taken only while no ack stands: a held strobe must not pop twice
   wire acc_ok   = reg_sel && !reg_ack && (!reg_group || grp_ok);
   wire slot_wr_nak = hit_slot && reg_wr && aux_s2_r;
   wire wr_ok    = acc_ok && reg_wr && !slot_wr_nak;
   wire soft_rst = set1_r[`EBR_B_HOLDRST];
   wire hw_rst   = hw_s2_r;
   wire any_rst  = hw_rst || soft_rst;

   assign no_slot_source      = !aux_s2_r;
   assign base_relocation_sel = set1_r[`EBR_B_SELADDR];
   assign module_reset        = any_rst;
   assign group_addr          = grp_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         set1_r <= '0;
      end else if (hw_rst) begin
         set1_r <= '0;
      end else begin
         if (wr_ok && hit_set)
            set1_r <= set1_r | (reg_wdata & `EBR_SET1_MASK);
         else if (wr_ok && hit_clr)
            set1_r <= set1_r & ~(reg_wdata & `EBR_SET1_MASK);
         if (soft_rst && !(wr_ok && hit_set && reg_wdata[`EBR_B_BERR]))
            set1_r[`EBR_B_BERR] <= 1'b0;
         if (blk_berr)
            set1_r[`EBR_B_BERR] <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         grp_r <= `EBR_GRP_RST;
      else if (hw_rst)
         grp_r <= `EBR_GRP_RST;
      else if (wr_ok && hit_grp)
         grp_r <= reg_wdata[7:0];
   end

   // slot code: written value waits, reset makes it current
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_r      <= `EBR_SLOT_RST;
         slot_wr_r   <= `EBR_SLOT_RST;
         slot_pend_r <= 1'b0;
         boot_r      <= `EBR_BOOT_INIT;
      end else begin
         boot_r <= boot_r >> 1;
         if (wr_ok && hit_slot) begin
            slot_wr_r   <= reg_wdata[4:0];
            slot_pend_r <= 1'b1;
         end
         if (boot_r[0] || any_rst) begin
            if (aux_s2_r)
               slot_r <= slot_s2_r;
            else if (slot_pend_r)
               slot_r <= slot_wr_r;
            slot_pend_r <= 1'b0;
         end
      end
   end

   // framer: scan channels in interleaved order
   localparam int NCH = CH16 ? 16 : 32;
   localparam int HALF = NCH / 2;
   ebr_fmt_e  st_r;
   logic [5:0] idx_r, cnt_r;
   logic [31:0] keep_r;
   logic [32*12-1:0] val_r;
   logic [31:0] good_r, below_r, over_r;
   logic        f_valid;
   logic        f_ready;
   ebr_word_t   f_data;
   wire [4:0] ch = 5'(idx_r[0] ? HALF + int'(idx_r[5:1]) : int'(idx_r[5:1]));
   wire last_idx = idx_r == 6'(NCH - 1);
   wire [31:0] keep_nxt = ch_enable
        & (ev_good  | {32{set_two[`EBR_S2_INVKEEP]}})
        & (~ev_below | {32{set_two[`EBR_S2_UNKEEP]}})
        & (~ev_over  | {32{set_two[`EBR_S2_OVKEEP]}});
   wire [5:0] keep_cnt = 6'($countones(CH16 ? {16'h0, keep_nxt[15:0]}
                                           : keep_nxt));
   wire [4:0] ch_field = CH16 ? {ch[3:0], 1'b0} : ch;

   assign ev_ready = (st_r == EBR_IDLE) && !any_rst;

   always_comb begin
      f_valid = 1'b0;
      f_data  = '0;
      case (st_r)
         EBR_HDR: begin
            f_valid = 1'b1;
            f_data  = {slot_r, `EBR_TYPE_HDR, crate_number,
                       2'b00, cnt_r, 8'h00};
         end
         EBR_DATA: begin
            f_valid = keep_r[ch];
            f_data  = {slot_r, `EBR_TYPE_DATA, 3'b000, ch_field, 1'b0,
                       good_r[ch], below_r[ch], over_r[ch],
                       val_r[12*ch +: 12]};
         end
         EBR_EOE: begin
            f_valid = 1'b1;
            f_data  = {slot_r, `EBR_TYPE_EOE, event_count};
         end
         default: begin
            f_valid = 1'b0;
            f_data  = '0;
         end
      endcase
   end

   // hazard: event_count must hold steady until the end word is queued
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= EBR_IDLE;
         idx_r <= '0;
         cnt_r <= '0;
         keep_r <= '0;
         val_r <= '0;
         good_r <= '0;
         below_r <= '0;
         over_r <= '0;
      end else if (any_rst) begin
         st_r <= EBR_IDLE;
      end else begin
         case (st_r)
            EBR_IDLE: if (ev_valid) begin
               keep_r  <= keep_nxt;
               cnt_r   <= keep_cnt;
               val_r   <= ev_value;
               good_r  <= ev_good;
               below_r <= ev_below;
               over_r  <= ev_over;
               idx_r   <= '0;
               st_r    <= EBR_HDR;
            end
            EBR_HDR: if (f_ready) st_r <= EBR_DATA;
            EBR_DATA: if (!f_valid || f_ready) begin
               idx_r <= idx_r + 6'd1;
               if (last_idx) st_r <= EBR_EOE;
            end
            EBR_EOE: if (f_ready) st_r <= EBR_IDLE;
            default: st_r <= EBR_IDLE;
         endcase
      end
   end

   // output buffer and read path
   logic      b_valid;
   ebr_word_t b_data;
   wire buf_rd = acc_ok && !reg_wr && hit_buf;
   ebr_fifo #(.WIDTH(32), .DEPTH(`EBR_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .flush     (any_rst),
      .in_valid  (f_valid),
      .in_ready  (f_ready),
      .in_data   (f_data),
      .out_valid (b_valid),
      .out_ready (buf_rd),
      .out_data  (b_data)
   );

   // filler carries no slot code, only its type
   wire ebr_word_t fill_w = {5'h00, `EBR_TYPE_FILL, 24'h000000};
   wire ebr_word_t rd_nxt = hit_buf  ? (b_valid ? b_data : fill_w) :
                            hit_slot ? {27'h0, slot_r} :
                            hit_grp  ? {24'h0, grp_r} :
                            (hit_set || hit_clr) ? {16'h0, set1_r} : '0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_ack   <= 1'b0;
         reg_rdata <= '0;
      end else begin
         reg_ack <= acc_ok && !slot_wr_nak && !reg_ack;
         if (acc_ok && !reg_wr) reg_rdata <= rd_nxt;
      end
   end

   AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      soft_rst && !hw_rst && !(wr_ok && hit_clr && reg_wdata[`EBR_B_HOLDRST])
      |=> soft_rst) else $error("hold reset dropped");
   AST_SLOTNAK: assert property (@(posedge clk) disable iff (!rstn)
      slot_wr_nak |=> !reg_ack) else $error("slot write acked");
   AST_GRPRD: assert property (@(posedge clk) disable iff (!rstn)
      reg_sel && reg_group && !reg_wr |=> !reg_ack)
      else $error("group read acked");
   AST_EMPTY: assert property (@(posedge clk) disable iff (!rstn)
      buf_rd && !b_valid |=> reg_rdata == fill_w)
      else $error("empty read not filler");
   AST_TYPE: assert property (@(posedge clk) disable iff (!rstn)
      f_valid |-> f_data[26:24] inside {`EBR_TYPE_HDR, `EBR_TYPE_DATA,
      `EBR_TYPE_EOE}) else $error("bad word type");
   AST_SLOTF: assert property (@(posedge clk) disable iff (!rstn)
      f_valid |-> f_data[31:27] == slot_r)
      else $error("slot code missing");
   AST_BERR: assert property (@(posedge clk) disable iff (!rstn)
      blk_berr && !hw_rst |=> set1_r[`EBR_B_BERR])
      else $error("error flag not set");
   AST_HDRN: assert property (@(posedge clk) disable iff (!rstn)
      st_r == EBR_IDLE && ev_valid && !any_rst |=> f_data[13:8] == cnt_r
      && cnt_r == $past(keep_cnt)) else $error("count wrong");
   AST_GRPRST: assert property (@(posedge clk) disable iff (!rstn)
      hw_rst |=> grp_r == `EBR_GRP_RST) else $error("group reset");
   COV_EVENT: cover property (@(posedge clk) disable iff (!rstn)
      st_r == EBR_EOE && f_ready);
   COV_FILL: cover property (@(posedge clk) disable iff (!rstn)
      buf_rd && !b_valid);
   COV_FULL: cover property (@(posedge clk) disable iff (!rstn)
      f_valid && !f_ready);
   COV_HOLD: cover property (@(posedge clk) disable iff (!rstn)
      soft_rst ##1 !soft_rst);
endmodule // ebr_event_readout

//--- sim/ebr_master_model.sv
// Purpose: bus master model issuing register and buffer cycles
// Assumes: ack is a one-cycle pulse after the taken edge
// Notes:   a refused cycle ends after a bounded wait, like a bus timeout
`timescale 1ns/1ps
module ebr_master_model (
   input  wire logic        clk,
   output logic             reg_sel,
   output logic             reg_wr,
   output logic             reg_group,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic        reg_ack,
   input  ebr_pkg::ebr_word_t reg_rdata
);
   import ebr_pkg::*;
   initial begin
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_group = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end
   // request held whole until the edge that sees ack
   task automatic access(input logic wr, input logic grp,
      input logic [15:0] a, input logic [15:0] d,
      output ebr_word_t rd, output logic acked);
      int n;
      acked = 1'b0;
      rd = 'x;
      @(posedge clk);
      reg_sel <= 1'b1;
      reg_wr <= wr;
      reg_group <= grp;
      reg_addr <= a;
      reg_wdata <= d;
      for (n = 0; n < 16 && !acked; n++) begin
         @(posedge clk);
         if (reg_ack === 1'b1) begin
            acked = 1'b1;
            rd = reg_rdata;
         end
      end
      reg_sel <= 1'b0;  // released after ack or after 16 edges without one
      // released lines must not keep looking valid
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule // ebr_master_model

//--- sim/ebr_event_readout_tb.sv
// Purpose: self-checking bench of the event readout block
// Assumes: 32-channel build, backplane slot lines at 0x0b
// Notes:   random events from a fixed seed plus hand-picked corners
`timescale 1ns/1ps
`include "ebr_defs.svh"
module ebr_event_readout_tb;
   import ebr_pkg::*;
   localparam logic [4:0] SLOT = 5'h0b;
   localparam ebr_word_t  FILL = {5'h0, `EBR_TYPE_FILL, 24'h0};
   logic         clk, rstn, hw_reset, aux_slot_connector, blk_berr;
   logic         ev_valid, ev_ready, reg_sel, reg_wr, reg_group, reg_ack;
   logic         no_slot_source, base_relocation_sel, module_reset, ack;
   logic [4:0]   backplane_slot_connector;
   logic [7:0]   crate_number, group_addr;
   logic [15:0]  set_two, reg_addr, reg_wdata;
   logic [383:0] ev_value;
   logic [31:0]  ev_good, ev_below, ev_over, ch_enable;
   logic [23:0]  event_count;
   ebr_word_t    reg_rdata, rd;
   ebr_word_t    exp_q[$];
   int           mismatches = 0;
   int           checks = 0;
   int           seed = 78;

   ebr_event_readout #(.CH16(1'b0)) ebr_event_readout_inst (
      .clk(clk), .rstn(rstn), .hw_reset(hw_reset),
      .backplane_slot_connector(backplane_slot_connector),
      .aux_slot_connector(aux_slot_connector),
      .crate_number(crate_number), .set_two(set_two),
      .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_value(ev_value),
      .ev_good(ev_good), .ev_below(ev_below), .ev_over(ev_over),
      .ch_enable(ch_enable), .event_count(event_count),
      .blk_berr(blk_berr), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_group(reg_group), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_ack(reg_ack), .reg_rdata(reg_rdata),
      .no_slot_source(no_slot_source),
      .base_relocation_sel(base_relocation_sel),
      .module_reset(module_reset), .group_addr(group_addr));
   ebr_master_model ebr_master_model_inst (
      .clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_group(reg_group), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_ack(reg_ack), .reg_rdata(reg_rdata));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic rw(input logic wr, input logic grp,
      input logic [15:0] a, input logic [15:0] d);
      ebr_master_model_inst.access(wr, grp, a, d, rd, ack);
   endtask
   task automatic reg_is(input logic [15:0] a, input logic [15:0] v);
      rw(1'b0, 1'b0, a, 16'h0);
      check({16'h0, rd[15:0]}, {16'h0, v}, "register");
   endtask
   task automatic hw_pulse();
      @(posedge clk);
      hw_reset <= 1'b1;
      repeat (4) @(posedge clk);
      hw_reset <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   function automatic logic keep(int c);
      return ch_enable[c] && (ev_good[c] || set_two[`EBR_S2_INVKEEP]) &&
         (!ev_below[c] || set_two[`EBR_S2_UNKEEP]) &&
         (!ev_over[c] || set_two[`EBR_S2_OVKEEP]);
   endfunction
   function automatic ebr_word_t dword(int c);
      return {SLOT, `EBR_TYPE_DATA, 3'h0, c[4:0], 1'b0, ev_good[c],
         ev_below[c], ev_over[c], ev_value[12*c+:12]};
   endfunction
   task automatic event_test(input bit full, input int stall);
      int i, c, n, tries;
      @(posedge clk);
      for (i = 0; i < 12; i++) ev_value[32*i+:32] <= $random(seed);
      ev_good <= full ? '1 : $random(seed);
      ev_below <= full ? '0 : $random(seed);
      ev_over <= full ? '0 : $random(seed);
      ch_enable <= full ? '1 : $random(seed);
      set_two <= full ? 16'h0 : {10'h0, 3'($random(seed)), 3'h0};
      crate_number <= 8'($random(seed));
      event_count <= 24'($random(seed));
      ev_valid <= 1'b1;
      for (tries = 0; tries < 50; tries++) begin
         @(posedge clk);
         if (ev_ready === 1'b1) break;
      end
      ev_valid <= 1'b0;
      exp_q.delete();
      n = 0;
      for (i = 0; i < 32; i++) begin
         c = (i % 2) ? 16 + i / 2 : i / 2;
         if (keep(c)) begin
            exp_q.push_back(dword(c));
            n++;
         end
      end
      exp_q.push_front({SLOT, `EBR_TYPE_HDR, crate_number, 2'h0, n[5:0],
         8'h0});
      exp_q.push_back({SLOT, `EBR_TYPE_EOE, event_count});
      repeat (stall) @(posedge clk);
      if (stall > 0) check({31'h0, ev_ready}, 32'h0, "full stall");
      tries = 0;
      while (exp_q.size() > 0 && tries < 300) begin
         rw(1'b0, 1'b0, {4'h0, 10'($random(seed)), 2'b00}, 16'h0);
         tries++;
         if (rd !== FILL) check(rd, exp_q.pop_front(), "word");
      end
      check(32'(exp_q.size()), 32'h0, "words lost");
      rw(1'b0, 1'b0, `EBR_OFF_BUF, 16'h0);
      check(rd, FILL, "empty read");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("MISMATCH %0t: watchdog expired", $time);
      complete_run();
   end

   initial begin
      {rstn, hw_reset, blk_berr, ev_valid} = 4'h0;
      {set_two, ev_value, ev_good, ev_below, ev_over, ch_enable} = '0;
      {crate_number, event_count} = '0;
      backplane_slot_connector = SLOT;
      aux_slot_connector = 1'b1;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check({24'h0, group_addr}, {24'h0, `EBR_GRP_RST}, "grp");
      reg_is(`EBR_OFF_GRP, {8'h0, `EBR_GRP_RST});
      reg_is(`EBR_OFF_SLOT, {11'h0, SLOT});
      hw_pulse();
      reg_is(`EBR_OFF_SLOT, {11'h0, SLOT});
      $display("test reset values done");
      rw(1'b1, 1'b0, `EBR_OFF_SET1, 16'h0010);
      reg_is(`EBR_OFF_SET1, 16'h0010);
      check({31'h0, base_relocation_sel}, 32'h1, "sel");
      rw(1'b1, 1'b0, `EBR_OFF_SET1, 16'h0008);
      reg_is(`EBR_OFF_CLR1, 16'h0018);
      rw(1'b1, 1'b0, `EBR_OFF_CLR1, 16'h0010);
      reg_is(`EBR_OFF_SET1, 16'h0008);
      check({31'h0, base_relocation_sel}, 32'h0, "sel");
      rw(1'b1, 1'b0, `EBR_OFF_SET1, 16'h0080);
      repeat (8) @(posedge clk);
      check({31'h0, module_reset}, 32'h1, "held");
      reg_is(`EBR_OFF_SET1, 16'h0080);
      rw(1'b1, 1'b0, `EBR_OFF_CLR1, 16'h0080);
      repeat (2) @(posedge clk);
      check({31'h0, module_reset}, 32'h0, "released");
      blk_berr <= 1'b1;
      @(posedge clk);
      blk_berr <= 1'b0;
      reg_is(`EBR_OFF_SET1, 16'h0008);
      rw(1'b1, 1'b0, `EBR_OFF_GRP, 16'h0055);
      reg_is(`EBR_OFF_GRP, 16'h0055);
      hw_pulse();
      reg_is(`EBR_OFF_SET1, 16'h0000);
      check({24'h0, group_addr}, {24'h0, `EBR_GRP_RST}, "grp");
      $display("test control registers done");
      rw(1'b1, 1'b0, `EBR_OFF_SLOT, 16'h0005);
      check({31'h0, ack}, 32'h0, "slot write");
      rw(1'b0, 1'b1, `EBR_OFF_SET1, 16'h0);
      check({31'h0, ack}, 32'h0, "group read");
      rw(1'b1, 1'b1, `EBR_OFF_GRP, 16'h0033);
      check({31'h0, ack}, 32'h0, "group low");
      rw(1'b1, 1'b1, `EBR_OFF_MC_HI + 16'h1, 16'h0);
      check({31'h0, ack}, 32'h0, "group high");
      rw(1'b1, 1'b1, `EBR_OFF_SET1, 16'h0010);
      check({31'h0, base_relocation_sel}, 32'h1, "group ok");
      rw(1'b0, 1'b0, 16'h1040, 16'h0);
      check({31'h0, ack}, 32'h1, "unmapped");
      aux_slot_connector <= 1'b0;
      repeat (4) @(posedge clk);
      check({31'h0, no_slot_source}, 32'h1, "no source");
      rw(1'b1, 1'b0, `EBR_OFF_SLOT, 16'h0005);
      reg_is(`EBR_OFF_SLOT, {11'h0, SLOT});
      hw_pulse();  // new slot value needs a reset
      reg_is(`EBR_OFF_SLOT, 16'h0005);
      aux_slot_connector <= 1'b1;
      hw_pulse();
      reg_is(`EBR_OFF_SLOT, {11'h0, SLOT});
      $display("test slot and group access done");
      event_test(1'b1, 60);
      repeat (8) event_test(1'b0, $random(seed) & 15);
      $display("test events done");
      complete_run();
   end
endmodule // ebr_event_readout_tb
